// ==== common/dmaarc_pkg.sv ====
package dmaarc_pkg;

   // Address field widths and positions.
   localparam int PAGE_W = 8;
   localparam int MID_W = 8;
   localparam int LOW_W = 8;
   localparam int XA_W = 17;
   localparam int UP_W = 7;
   localparam int CHAN_W = 3;
   localparam int NCHAN = 8;
   localparam int NREQ = 8;
   localparam int XA_MID8_LSB = 8;
   localparam int XA_MID16_LSB = 9;
   localparam int XA_LOW16_LSB = 1;
   localparam int XA_TOP = 16;
   localparam int PAGE_XA16_BIT = 0;
   localparam int PAGE_UP_LSB = 1;

   // Timing in system clocks (clk runs at 200 MHz, 5 ns period).
   localparam int CLK_PERIOD_PS = 5000;
   localparam int DMA_CLK_DIV = 2;
   localparam int CORE_MEMORY_READ_STROBE_DELAY_DMA_CLKS = 1;
   localparam logic [1:0] CORE_MEMORY_READ_STROBE_DELAY = 2'(CORE_MEMORY_READ_STROBE_DELAY_DMA_CLKS * DMA_CLK_DIV);
   localparam logic [2:0] REFRESH_LEN = 3'h4;

   // Reset values of synchronised pins: requests idle low, ready and master idle high.
   localparam logic [NREQ+1:0] SYNC_RESET = {8'h00, 1'b1, 1'b1};
   localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
   localparam logic [MID_W-1:0] MID_RESET = 8'h00;

   typedef enum logic [2:0] {
      RDY_IDLE = 3'h1,
      RDY_FORCED = 3'h2,
      RDY_EXTEND = 3'h4
   } dmaarc_rdy_t;

   typedef enum logic [4:0] {
      ARB_IDLE = 5'h01,
      ARB_DMA_WAIT = 5'h02,
      ARB_DMA = 5'h04,
      ARB_REF_WAIT = 5'h08,
      ARB_REF = 5'h10
   } dmaarc_arb_t;

   // Signals from the active controller core.
   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic wide;
      logic active;
      logic cascade;
      logic addr_strobe;
      logic xfer_start;
      logic core_memory_read_strobe_n;
      logic hold_req;
      logic [LOW_W-1:0] low;
      logic [MID_W-1:0] data;
   } dmaarc_core_t;

   typedef struct packed {
      logic [XA_W-1:0] addr;
      logic oe;
   } dmaarc_xa_t;

   typedef struct packed {
      logic [UP_W-1:0] addr;
      logic oe;
   } dmaarc_up_t;

endpackage

// ==== logic/dmaarc_sync.sv ====
`timescale 1ns/1ps
module dmaarc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] stage1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= RESET_VALUE;
         q <= RESET_VALUE;
      end else if (clk_en) begin
         stage1 <= d;
         q <= stage1;
      end
   end

endmodule

// ==== logic/dmaarc_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Page value drives upper address lines
// [RULE_02] Middle portion refreshed at start, block crossing
// [RULE_03] Latch core data during address strobe
// [RULE_04] Middle latch drives XA8-15 or XA9-16
// [RULE_05] Core low byte drives XA0-7 or XA1-8
// [RULE_06] XA0 low for every 16-bit transfer
// [RULE_07] Both cores share one ready signal
// [RULE_08] Exactly one forced wait state per transfer
// [RULE_09] Slow device pulls ready low early
// [RULE_10] Keep waiting while channel ready is low
// [RULE_11] Late ready rise costs one extra wait
// [RULE_12] Delayed read strobe falls two clocks later
// [RULE_13] Delayed read strobe rises with raw strobe
// [RULE_14] Board wires cascade channel to external controller
// [RULE_15] Cascade acknowledge floats data, commands, XA
// [RULE_16] Cascade acknowledge still drives page value
// [RULE_17] Master pulls master pin only after acknowledge
// [RULE_18] Upper address floats while master pin low
// [RULE_19] Arbiter takes DMA and refresh timer requests
// [RULE_20] DMA sampled rising, timer sampled falling edge
// [RULE_21] First captured request wins, other waits
// [RULE_22] DMA clock runs at half system rate
// [RULE_23] Address counting never touches page bits
// [RULE_24] Grant passes over without dropping CPU hold
// [RULE_25] Asynchronous inputs pass two-flop synchroniser
module dmaarc_top
   import dmaarc_pkg::*;
(
   // Clock, reset and freeze
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Controller cores
   input wire dmaarc_core_t core,
   output logic core_ready,
   output logic core_hold_ack,
   output logic [NREQ-1:0] core_request,
   // Page register load port
   input wire logic page_we,
   input wire logic [CHAN_W-1:0] page_sel,
   input wire logic [PAGE_W-1:0] page_wdata,
   // Expansion bus pins
   input wire logic [NREQ-1:0] dma_request_line,
   input wire logic channel_ready_input,
   input wire logic master_n,
   output dmaarc_xa_t peripheral_address_bus,
   output dmaarc_up_t upper_address,
   output logic delayed_memory_read_strobe_n,
   output logic cmd_data_oe,
   output logic refresh_n_out,
   output logic refresh_n_oe,
   // Processor hold handshake and refresh timer
   input wire logic timer1_out,
   input wire logic cpu_hold_ack,
   output logic processor_hold_request
);

   logic [NREQ+1:0] sync_q;
   logic [NREQ-1:0] dma_req_s;
   logic chan_rdy_s;
   logic mst_n_s;
   logic dma_phase;
   logic [PAGE_W-1:0] page [NCHAN];
   logic [MID_W-1:0] mid8;
   logic [MID_W-1:0] mid16;
   logic [1:0] mlow_cnt;
   logic dma_req_q;
   logic tmr_q;
   logic ref_pend;
   logic [2:0] ref_cnt;
   dmaarc_rdy_t rdy_state;
   dmaarc_rdy_t next_rdy;
   dmaarc_arb_t arb_state;
   dmaarc_arb_t next_arb;

   // [RULE_25] two-flop synchroniser
   dmaarc_sync #(
      .W(NREQ + 2),
      .RESET_VALUE(SYNC_RESET)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .d({dma_request_line, channel_ready_input, master_n}),
      .q(sync_q)
   );

   assign dma_req_s = sync_q[NREQ+1:2];
   assign chan_rdy_s = sync_q[1];
   assign mst_n_s = sync_q[0];

   // [RULE_22] half-rate DMA clock
   wire dma_rise = clk_en && !dma_phase;
   wire dma_fall = clk_en && dma_phase;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_phase <= 1'b0;
      end else if (clk_en) begin
         dma_phase <= !dma_phase;
      end
   end

   // Address composition.
   wire [PAGE_W-1:0] sel_page = page[core.chan];
   wire xa_drive = core.active && !core.cascade && mst_n_s;
   wire up_drive = core.active && mst_n_s;
   wire [XA_W-1:0] xa8;
   wire [XA_W-1:0] xa16;
   // [RULE_01] page bit feeds XA16 on byte channels
   // [RULE_04] byte channel middle field
   // [RULE_05] byte channel low field
   assign xa8 = {sel_page[PAGE_XA16_BIT], mid8, core.low};
   // [RULE_06] word channels force XA0 low
   // [RULE_04] word channel middle field
   // [RULE_05] word channel low field
   assign xa16 = {mid16, core.low, 1'b0};
   wire [XA_W-1:0] next_xa = core.wide ? xa16 : xa8;
   // [RULE_23] page bits come only from the page register
   wire [UP_W-1:0] next_up = sel_page[PAGE_W-1:PAGE_UP_LSB];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NCHAN; i++) begin
            page[i] <= PAGE_RESET;
         end
      end else if (clk_en && page_we) begin
         page[page_sel] <= page_wdata;
      end
   end

   // The core only strobes at the start and on block crossings, so the latch needs no counter.
   // [RULE_02] middle refreshed on strobe
   // [RULE_03] capture middle byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mid8 <= MID_RESET;
         mid16 <= MID_RESET;
      end else if (clk_en && core.addr_strobe) begin
         if (core.wide) begin
            mid16 <= core.data;
         end else begin
            mid8 <= core.data;
         end
      end
   end

   // [RULE_15] cascade floats XA and commands
   // [RULE_16] cascade keeps page on upper lines
   // [RULE_18] master pin floats upper lines
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         peripheral_address_bus <= '0;
         upper_address <= '0;
         cmd_data_oe <= 1'b0;
      end else if (clk_en) begin
         peripheral_address_bus <= '{addr: next_xa, oe: xa_drive};
         upper_address <= '{addr: next_up, oe: up_drive};
         cmd_data_oe <= xa_drive;
      end
   end

   // Read strobe delay: counts edges the raw strobe has been low.
   wire [1:0] next_mlow = core.core_memory_read_strobe_n ? 2'h0 :
      (mlow_cnt == CORE_MEMORY_READ_STROBE_DELAY) ? mlow_cnt : mlow_cnt + 2'h1;
   // [RULE_12] fall held off two clocks
   // [RULE_13] rise follows raw strobe at once
   wire next_dmemr_n = core.core_memory_read_strobe_n || (mlow_cnt < CORE_MEMORY_READ_STROBE_DELAY);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mlow_cnt <= 2'h0;
         delayed_memory_read_strobe_n <= 1'b1;
      end else if (clk_en) begin
         mlow_cnt <= next_mlow;
         delayed_memory_read_strobe_n <= next_dmemr_n;
      end
   end

   // Ready control: ready is sampled on the DMA clock's second phase.
   always_comb begin
      next_rdy = rdy_state;
      unique case (rdy_state)
         RDY_IDLE: begin
            // [RULE_08] forced wait
            if (core.xfer_start) begin
               next_rdy = RDY_FORCED;
            end
         end
         RDY_FORCED: begin
            // [RULE_10] extend on low ready
            if (dma_fall) begin
               next_rdy = chan_rdy_s ? RDY_IDLE : RDY_EXTEND;
            end
         end
         RDY_EXTEND: begin
            // [RULE_11] late rise waits next sample
            if (dma_fall && chan_rdy_s) begin
               next_rdy = RDY_IDLE;
            end
         end
         default: next_rdy = RDY_IDLE;
      endcase
   end

   // [RULE_07] single shared ready
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_state <= RDY_IDLE;
         core_ready <= 1'b1;
         core_request <= '0;
      end else if (clk_en) begin
         rdy_state <= next_rdy;
         core_ready <= (next_rdy == RDY_IDLE);
         core_request <= dma_req_s;
      end
   end

   // Hold arbiter. Samples on opposite DMA clock edges never coincide, so no tie exists.
   // [RULE_19] two request sources
   // [RULE_20] opposite edge sampling
   wire tmr_rise = dma_fall && timer1_out && !tmr_q;
   wire ref_done = (ref_cnt >= REFRESH_LEN - 3'h1) && chan_rdy_s;
   wire ref_enter = (next_arb == ARB_REF) && (arb_state != ARB_REF);

   always_comb begin
      next_arb = arb_state;
      unique case (arb_state)
         ARB_IDLE: begin
            // [RULE_21] first captured wins
            if (dma_req_q) begin
               next_arb = ARB_DMA_WAIT;
            end else if (ref_pend) begin
               next_arb = ARB_REF_WAIT;
            end
         end
         ARB_DMA_WAIT: begin
            if (cpu_hold_ack) begin
               next_arb = ARB_DMA;
            end
         end
         ARB_DMA: begin
            // [RULE_24] hand over to refresh
            if (!dma_req_q) begin
               next_arb = ref_pend ? ARB_REF : ARB_IDLE;
            end
         end
         ARB_REF_WAIT: begin
            if (cpu_hold_ack) begin
               next_arb = ARB_REF;
            end
         end
         ARB_REF: begin
            // [RULE_24] hand over to DMA
            if (ref_done) begin
               next_arb = dma_req_q ? ARB_DMA : ARB_IDLE;
            end
         end
         default: next_arb = ARB_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_req_q <= 1'b0;
         tmr_q <= 1'b0;
         ref_pend <= 1'b0;
      end else begin
         if (dma_rise) begin
            dma_req_q <= core.hold_req;
         end
         if (dma_fall) begin
            tmr_q <= timer1_out;
         end
         // A timer edge in the cycle the grant is taken stays pending.
         if (tmr_rise) begin
            ref_pend <= 1'b1;
         end else if (clk_en && ref_enter) begin
            ref_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arb_state <= ARB_IDLE;
         ref_cnt <= 3'h0;
         processor_hold_request <= 1'b0;
         core_hold_ack <= 1'b0;
         refresh_n_oe <= 1'b0;
         refresh_n_out <= 1'b0;
      end else if (clk_en) begin
         arb_state <= next_arb;
         ref_cnt <= (arb_state == ARB_REF && next_arb == ARB_REF) ? ref_cnt + 3'h1 : 3'h0;
         processor_hold_request <= (next_arb != ARB_IDLE);
         core_hold_ack <= (next_arb == ARB_DMA);
         refresh_n_oe <= (next_arb == ARB_REF);
         refresh_n_out <= 1'b0;
      end
   end

   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n || !clk_en);
   sequence s_core_memory_read_strobe_fall3;
      core.core_memory_read_strobe_n ##1 !core.core_memory_read_strobe_n [*3];
   endsequence
   sequence s_core_memory_read_strobe_fall2;
      core.core_memory_read_strobe_n ##1 !core.core_memory_read_strobe_n [*2];
   endsequence

   a_core_memory_read_strobe_late_fall: assert property (s_core_memory_read_strobe_fall3 |=> !delayed_memory_read_strobe_n) // RULE_12
      else $error("delayed read strobe did not fall two clocks late");
   a_core_memory_read_strobe_no_early: assert property (s_core_memory_read_strobe_fall2 |=> delayed_memory_read_strobe_n) // RULE_12
      else $error("delayed read strobe fell too early");
   a_core_memory_read_strobe_rise_now: assert property (core.core_memory_read_strobe_n |=> delayed_memory_read_strobe_n) // RULE_13
      else $error("delayed read strobe rise was delayed");
   a_ready_forced: assert property ( // RULE_08
      rdy_state == RDY_IDLE && core.xfer_start |=> !core_ready) else $error("no forced wait");
   a_ready_extend: assert property ( // RULE_10
      rdy_state != RDY_IDLE && !chan_rdy_s |=> !core_ready) else $error("ready while held low");
   a_xa0_word: assert property (core.wide |=> peripheral_address_bus.addr[0] == 1'b0) // RULE_06
      else $error("address bit 0 not low on word channel");
   a_cascade_float: assert property ( // RULE_15
      core.cascade |=> !peripheral_address_bus.oe && !cmd_data_oe) else $error("bus not floated");
   a_cascade_page: assert property ( // RULE_16
      core.active && mst_n_s |=> upper_address.oe && upper_address.addr == $past(next_up))
      else $error("page value missing on upper address lines");
   a_master_float: assert property (!mst_n_s |=> !upper_address.oe) // RULE_18
      else $error("upper address driven while master pin low");
   a_hold_handover: assert property ( // RULE_24
      arb_state == ARB_DMA && !dma_req_q && ref_pend |=> processor_hold_request && refresh_n_oe)
      else $error("hold dropped between grants");
   a_refresh_len: assert property ($rose(refresh_n_oe) |-> refresh_n_oe [*4]) // RULE_24
      else $error("refresh cycle shorter than four clocks");
endmodule

// ==== sim/dmaarc_adapter.sv ====
`timescale 1ns/1ps
module dmaarc_adapter (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Processor hold handshake
   input wire logic processor_hold_request,
   output logic cpu_hold_ack,
   // Slow expansion card
   input wire logic core_active,
   input wire logic xfer_start,
   input wire logic [3:0] slow_cycles,
   output logic channel_ready_input
);
   logic [1:0] hold_age;
   logic [3:0] wait_age;

   // The processor grants the bus a little after the request, never at once.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_age <= 2'h0;
         cpu_hold_ack <= 1'b0;
      end else begin
         if (!processor_hold_request) begin
            hold_age <= 2'h0;
         end else if (hold_age != 2'h3) begin
            hold_age <= hold_age + 2'h1;
         end
         cpu_hold_ack <= processor_hold_request && (hold_age >= 2'h2);
      end
   end

   // early ready pull
   // The card pulls ready low as soon as it is acknowledged, so the low level has
   // crossed the synchroniser before the forced wait state is sampled.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_age <= 4'h0;
         channel_ready_input <= 1'b1;
      end else begin
         if (!core_active) begin
            wait_age <= 4'h0;
         end else if (xfer_start || (wait_age != 4'h0 && wait_age != 4'hF)) begin
            wait_age <= wait_age + 4'h1;
         end
         channel_ready_input <= !(core_active && (wait_age < slow_cycles));
      end
   end
endmodule

// ==== sim/dmaarc_top_test.sv ====
`timescale 1ns/1ps
module dmaarc_top_test
   import dmaarc_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   dmaarc_core_t core = '0;
   logic page_we = 1'b0;
   logic [CHAN_W-1:0] page_sel = '0;
   logic [PAGE_W-1:0] page_wdata = '0;
   logic [NREQ-1:0] dma_request_line = '0;
   logic master_n = 1'b1;
   logic timer1_out = 1'b0;
   logic [3:0] slow_cycles = 4'h0;
   logic channel_ready_input;
   logic cpu_hold_ack;
   logic core_ready;
   logic core_hold_ack;
   logic [NREQ-1:0] core_request;
   dmaarc_xa_t peripheral_address_bus;
   dmaarc_up_t upper_address;
   logic delayed_memory_read_strobe_n;
   logic cmd_data_oe;
   logic refresh_n_out;
   logic refresh_n_oe;
   logic processor_hold_request;
   int err_total = 0;
   int total_checks = 0;

   dmaarc_top i_dmaarc_top (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .core(core),
      .core_ready(core_ready), .core_hold_ack(core_hold_ack), .core_request(core_request),
      .page_we(page_we), .page_sel(page_sel), .page_wdata(page_wdata),
      .dma_request_line(dma_request_line), .channel_ready_input(channel_ready_input),
      .master_n(master_n), .peripheral_address_bus(peripheral_address_bus),
      .upper_address(upper_address),
      .delayed_memory_read_strobe_n(delayed_memory_read_strobe_n),
      .cmd_data_oe(cmd_data_oe), .refresh_n_out(refresh_n_out), .refresh_n_oe(refresh_n_oe),
      .timer1_out(timer1_out), .cpu_hold_ack(cpu_hold_ack),
      .processor_hold_request(processor_hold_request)
   );

   dmaarc_adapter i_dmaarc_adapter (
      .clk(clk), .rst_n(rst_n), .processor_hold_request(processor_hold_request),
      .cpu_hold_ack(cpu_hold_ack), .core_active(core.active), .xfer_start(core.xfer_start),
      .slow_cycles(slow_cycles), .channel_ready_input(channel_ready_input)
   );

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic final_report;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic timeout;
      err_total++;
      final_report();
   endtask

   task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      check_val(17'(got), 17'(exp));
   endtask

   task automatic page_write(input logic [2:0] ch, input logic [7:0] v);
      page_we = 1'b1;
      page_sel = ch;
      page_wdata = v;
      @(negedge clk);
      page_we = 1'b0;
   endtask

   task automatic sync_case;
      dma_request_line = 8'h5A;
      @(negedge clk);
      check_val(17'(core_request), 17'h0);
      repeat (2) @(negedge clk);
      check_val(17'(core_request), 17'h5A);
      dma_request_line = 8'h00;
   endtask

   task automatic addr_case(input logic [2:0] ch, input logic w, input logic [7:0] pg,
                            input logic [7:0] d, input logic [7:0] lo);
      logic [7:0] d2;
      logic [7:0] lo2;
      d2 = d + 8'h01;
      lo2 = lo + 8'h01;
      page_write(ch, pg);
      core.chan = ch;
      core.wide = w;
      core.active = 1'b1;
      core.data = d;
      core.low = lo;
      core.addr_strobe = 1'b1;
      @(negedge clk);
      core.addr_strobe = 1'b0;
      // The bus moves on after the strobe, so only a real latch keeps the middle byte.
      core.data = ~d;
      repeat (2) @(negedge clk);
      check_val(peripheral_address_bus.addr, w ? {d, lo, 1'b0} : {pg[0], d, lo});
      check_flag(peripheral_address_bus.addr[0], w ? 1'b0 : lo[0]);
      check_flag(peripheral_address_bus.oe, 1'b1);
      check_flag(cmd_data_oe, 1'b1);
      check_val(17'(upper_address.addr), 17'(pg[7:1]));
      check_flag(upper_address.oe, 1'b1);
      // A new block brings a fresh strobe, and the latch must follow it.
      core.low = lo2;
      core.data = d2;
      core.addr_strobe = 1'b1;
      @(negedge clk);
      core.addr_strobe = 1'b0;
      core.data = ~d2;
      @(negedge clk);
      check_val(peripheral_address_bus.addr, w ? {d2, lo2, 1'b0} : {pg[0], d2, lo2});
      check_val(17'(upper_address.addr), 17'(pg[7:1]));
      core.active = 1'b0;
   endtask

   task automatic cascade_case;
      page_write(3'h2, 8'h6E);
      core.chan = 3'h2;
      core.wide = 1'b0;
      core.cascade = 1'b1;
      core.active = 1'b1;
      repeat (2) @(negedge clk);
      check_flag(peripheral_address_bus.oe, 1'b0);
      check_flag(cmd_data_oe, 1'b0);
      check_val(17'(upper_address.addr), 17'h37);
      check_flag(upper_address.oe, 1'b1);
      master_n = 1'b0;
      repeat (4) @(negedge clk);
      check_flag(upper_address.oe, 1'b0);
      master_n = 1'b1;
      repeat (4) @(negedge clk);
      check_flag(upper_address.oe, 1'b1);
      core.active = 1'b0;
      core.cascade = 1'b0;
      @(negedge clk);
   endtask

   task automatic ready_case(input logic [3:0] slow);
      int i;
      int lows;
      slow_cycles = slow;
      core.active = 1'b1;
      repeat (4) @(negedge clk);
      core.xfer_start = 1'b1;
      @(negedge clk);
      core.xfer_start = 1'b0;
      lows = 0;
      for (i = 0; i < 40; i++) begin
         if (core_ready === 1'b0) lows++;
         @(negedge clk);
      end
      if (slow == 4'h0) begin
         check_flag(lows >= 1 && lows <= DMA_CLK_DIV, 1'b1);
      end else begin
         check_flag(lows > int'(slow), 1'b1);
      end
      check_flag(core_ready, 1'b1);
      core.active = 1'b0;
      slow_cycles = 4'h0;
      // The card must see the acknowledge drop before the next transfer.
      @(negedge clk);
   endtask

   task automatic core_memory_read_strobe_case;
      int tf;
      int tr;
      core.core_memory_read_strobe_n = 1'b0;
      tf = 0;
      while (delayed_memory_read_strobe_n === 1'b1 && tf < 20) begin
         @(negedge clk);
         tf++;
      end
      if (tf >= 20) timeout();
      repeat (3) @(negedge clk);
      core.core_memory_read_strobe_n = 1'b1;
      tr = 0;
      while (delayed_memory_read_strobe_n !== 1'b1 && tr < 20) begin
         @(negedge clk);
         tr++;
      end
      check_val(17'(tf - tr), 17'(CORE_MEMORY_READ_STROBE_DELAY));
      check_val(17'(tr), 17'h1);
   endtask

   task automatic arb_case;
      int i;
      int drops;
      int n;
      core.hold_req = 1'b1;
      for (i = 0; i < 30 && core_hold_ack !== 1'b1; i++) @(negedge clk);
      if (core_hold_ack !== 1'b1) timeout();
      check_flag(processor_hold_request, 1'b1);
      timer1_out = 1'b1;
      repeat (4) @(negedge clk);
      check_flag(refresh_n_oe, 1'b0);
      core.hold_req = 1'b0;
      drops = 0;
      for (i = 0; i < 30 && refresh_n_oe !== 1'b1; i++) begin
         @(negedge clk);
         if (processor_hold_request !== 1'b1) drops++;
      end
      if (refresh_n_oe !== 1'b1) timeout();
      check_val(17'(drops), 17'h0);
      check_flag(refresh_n_out, 1'b0);
      n = 0;
      while (refresh_n_oe === 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check_val(17'(n), 17'(REFRESH_LEN));
      for (i = 0; i < 10 && processor_hold_request !== 1'b0; i++) @(negedge clk);
      check_flag(processor_hold_request, 1'b0);
      timer1_out = 1'b0;
      repeat (2) @(negedge clk);
      timer1_out = 1'b1;
      for (i = 0; i < 30 && refresh_n_oe !== 1'b1; i++) @(negedge clk);
      if (refresh_n_oe !== 1'b1) timeout();
      core.hold_req = 1'b1;
      @(negedge clk);
      check_flag(core_hold_ack, 1'b0);
      drops = 0;
      for (i = 0; i < 30 && core_hold_ack !== 1'b1; i++) begin
         @(negedge clk);
         if (processor_hold_request !== 1'b1) drops++;
      end
      check_flag(core_hold_ack, 1'b1);
      check_val(17'(drops), 17'h0);
      core.hold_req = 1'b0;
      timer1_out = 1'b0;
   endtask

   task automatic freeze_case;
      clk_en = 1'b0;
      dma_request_line = 8'h3C;
      repeat (4) @(negedge clk);
      check_val(17'(core_request), 17'h0);
      clk_en = 1'b1;
      repeat (3) @(negedge clk);
      check_val(17'(core_request), 17'h3C);
      dma_request_line = 8'h00;
   endtask

   initial begin
      core.core_memory_read_strobe_n = 1'b1;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check_flag(core_ready, 1'b1);
      check_flag(processor_hold_request, 1'b0);
      check_flag(delayed_memory_read_strobe_n, 1'b1);
      check_flag(peripheral_address_bus.oe, 1'b0);
      sync_case();
      addr_case(3'h1, 1'b0, 8'hA5, 8'h3C, 8'hFF);
      addr_case(3'h5, 1'b1, 8'h5B, 8'h43, 8'h81);
      cascade_case();
      ready_case(4'h0);
      ready_case(4'h6);
      core_memory_read_strobe_case();
      arb_case();
      freeze_case();
      final_report();
   end
endmodule
